// ### shared/tgc_map.vh
// Register offsets, field positions and reset values of the MAC configuration fields.
// Summary of operation
// - Preamble keep bit passes received preamble onward
// - Bit 25 set skips length/type checks
// - Bit 24 set spares long control frames
// - Low half holds pause address upper bits
// - Transmit reset bit restores defaults, self-clears
// - Jumbo bit allows overlong transmit frames
// - In-band check sequence passed unchanged
// - Otherwise pad, compute and append sequence
// - Transmit enable defaults on, gates transmitter
// - VLAN frames sent only when enabled
// - WAN mode stretches gaps to SONET rate
// - Gap adjust samples delay at frame start
// - Gap adjust ignored while WAN mode set
// - Deficit idle count shortens some gaps
// - Without deficit count or gap adjust, stretch to alignment
// - Gap adjust clears deficit idle count bit unless WAN mode set
// - Custom preamble sent when bit 23 set
// - Pause request honoured when bit 30 set
// - Received pause suspends transmitter when enabled
// - Otherwise pause frames forwarded, transmitter unaffected
// - Receive/transmit changes apply in gaps; pause bits and transmit reset act at once
// - Words reached through management register bank
`ifndef TGC_MAP_VH
`define TGC_MAP_VH
`define TGC_ADDR_RX1        11'h404
`define TGC_ADDR_TX         11'h408
`define TGC_ADDR_FC         11'h40c
`define TGC_RX1_KEEP_PRE    26
`define TGC_RX1_LT_DIS      25
`define TGC_RX1_CTL_LEN_DIS 24
`define TGC_TX_RESET        31
`define TGC_TX_JUMBO        30
`define TGC_TX_INBAND       29
`define TGC_TX_ENABLE       28
`define TGC_TX_VLAN         27
`define TGC_TX_WAN          26
`define TGC_TX_IFG_ADJ      25
`define TGC_TX_DIC          24
`define TGC_TX_KEEP_PRE     23
`define TGC_FC_TX_EN        30
`define TGC_FC_RX_EN        29
`define TGC_RX1_MASK        32'h0700ffff
`define TGC_TX_MASK         32'h7f800000
`define TGC_FC_MASK         32'h60000000
`define TGC_RX1_RESET       32'h00000000
`define TGC_TX_RESET_VAL    32'h10000000
`define TGC_FC_RESET        32'h60000000
`endif

// ### src/tgc_apply.v
// Holds a shadow copy of a configuration word, updated in a gap or on a forced load.
`timescale 1ns/1ns
module tgc_apply #(
  parameter [31:0] RESET_VAL = 32'h00000000
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        force_load,
  input  wire        in_gap,
  input  wire [31:0] staged,
  output reg  [31:0] active
);
  // A change mid-frame would corrupt the frame, so it waits for a gap.
  always @(posedge ref_clk) begin
    if (reset) begin
      active <= RESET_VAL;
    end else if (force_load || in_gap) begin
      active <= staged;
    end
  end
endmodule

// ### src/tgc_config.v
// Configuration register bank for the MAC receive, transmit and pause logic.
`timescale 1ns/1ns
`include "tgc_map.vh"
module tgc_config (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [10:0] host_addr,
  input  wire        host_wr,
  input  wire        host_rd,
  input  wire [31:0] host_wdata,
  output reg  [31:0] host_rdata,
  output reg         host_rd_valid,
  input  wire        rx_in_gap,
  input  wire        tx_in_gap,
  input  wire        pause_req,
  input  wire        pause_frame_rx,
  output reg         rx_keep_preamble,
  output reg         rx_len_type_check,
  output reg         rx_ctl_len_check,
  output reg  [15:0] pause_addr_upper,
  output reg         tx_soft_reset,
  output reg         tx_jumbo,
  output reg         tx_inband_fcs,
  output reg         tx_pad_and_fcs,
  output reg         tx_run,
  output reg         tx_vlan_allow,
  output reg         tx_wan_mode,
  output reg         tx_ifg_adjust,
  output reg         tx_deficit_idle,
  output reg         tx_stretch_align,
  output reg         tx_custom_preamble,
  output reg         pause_send,
  output reg         pause_suspend_tx,
  output reg         pause_forward
);
  reg  [31:0] rx1_staged;
  reg  [31:0] tx_staged;
  reg  [31:0] fc_staged;
  reg         tx_rst_pend;
  wire [31:0] rx1_act;
  wire [31:0] tx_act;
  wire [31:0] tx_view;
  wire [31:0] next_tx;
  wire        wr_rx1;
  wire        wr_tx;
  wire        wr_fc;
  wire        adj_eff;

  assign wr_rx1 = host_wr && (host_addr == `TGC_ADDR_RX1);
  assign wr_tx  = host_wr && (host_addr == `TGC_ADDR_TX);
  assign wr_fc  = host_wr && (host_addr == `TGC_ADDR_FC);

  // Gap adjust without WAN mode forces the deficit count bit off so it also reads back zero.
  assign next_tx = (host_wdata[`TGC_TX_IFG_ADJ] &&
                    !host_wdata[`TGC_TX_WAN]) ?
                   (host_wdata & `TGC_TX_MASK &
                    ~(32'h00000001 << `TGC_TX_DIC)) :
                   (host_wdata & `TGC_TX_MASK);

  always @(posedge ref_clk) begin
    if (reset) begin
      rx1_staged  <= `TGC_RX1_RESET;
      tx_staged   <= `TGC_TX_RESET_VAL;
      fc_staged   <= `TGC_FC_RESET;
      tx_rst_pend <= 1'b0;
    end else begin
      tx_rst_pend <= 1'b0;
      if (wr_rx1) begin
        rx1_staged <= host_wdata & `TGC_RX1_MASK;
      end
      if (wr_fc) begin
        fc_staged <= host_wdata & `TGC_FC_MASK;
      end
      if (wr_tx && host_wdata[`TGC_TX_RESET]) begin
        // The reset bit is never stored, so it reads back as cleared.
        tx_staged   <= `TGC_TX_RESET_VAL;
        tx_rst_pend <= 1'b1;
      end else if (wr_tx) begin
        tx_staged <= next_tx;
      end
    end
  end

  tgc_apply #(
    .RESET_VAL (`TGC_RX1_RESET)
  ) u_rx1 (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .force_load (1'b0),
    .in_gap     (rx_in_gap),
    .staged     (rx1_staged),
    .active     (rx1_act)
  );

  tgc_apply #(
    .RESET_VAL (`TGC_TX_RESET_VAL)
  ) u_tx (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .force_load (tx_rst_pend),
    .in_gap     (tx_in_gap),
    .staged     (tx_staged),
    .active     (tx_act)
  );

  always @(posedge ref_clk) begin
    if (reset) begin
      host_rdata    <= 32'h00000000;
      host_rd_valid <= 1'b0;
    end else begin
      host_rd_valid <= host_rd;
      case (host_addr)
        `TGC_ADDR_RX1: host_rdata <= rx1_staged;
        `TGC_ADDR_TX:  host_rdata <= tx_staged;
        `TGC_ADDR_FC:  host_rdata <= fc_staged;
        default:       host_rdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      rx_keep_preamble   <= 1'b0;
      rx_len_type_check  <= 1'b1;
      rx_ctl_len_check   <= 1'b1;
      pause_addr_upper   <= 16'h0000;
      tx_soft_reset      <= 1'b0;
      tx_jumbo           <= 1'b0;
      tx_inband_fcs      <= 1'b0;
      tx_pad_and_fcs     <= 1'b1;
      tx_run             <= 1'b1;
      tx_vlan_allow      <= 1'b0;
      tx_wan_mode        <= 1'b0;
      tx_ifg_adjust      <= 1'b0;
      tx_deficit_idle    <= 1'b0;
      tx_stretch_align   <= 1'b1;
      tx_custom_preamble <= 1'b0;
      pause_send         <= 1'b0;
      pause_suspend_tx   <= 1'b0;
      pause_forward      <= 1'b0;
    end else begin
      rx_keep_preamble  <= rx1_act[`TGC_RX1_KEEP_PRE];
      rx_len_type_check <= !rx1_act[`TGC_RX1_LT_DIS];
      rx_ctl_len_check  <= !rx1_act[`TGC_RX1_CTL_LEN_DIS];
      pause_addr_upper  <= rx1_act[15:0];
      tx_soft_reset     <= tx_rst_pend;
      tx_jumbo          <= tx_view[`TGC_TX_JUMBO];
      tx_inband_fcs     <= tx_view[`TGC_TX_INBAND];
      tx_pad_and_fcs    <= !tx_view[`TGC_TX_INBAND];
      tx_run            <= tx_view[`TGC_TX_ENABLE];
      tx_vlan_allow     <= tx_view[`TGC_TX_VLAN];
      tx_wan_mode       <= tx_view[`TGC_TX_WAN];
      tx_ifg_adjust     <= adj_eff;
      tx_deficit_idle   <= tx_view[`TGC_TX_DIC] && !adj_eff;
      tx_stretch_align  <= !tx_view[`TGC_TX_DIC] && !adj_eff;
      tx_custom_preamble <= tx_view[`TGC_TX_KEEP_PRE];
      // Pause bits act at once; they do not shape frames in flight.
      pause_send        <= pause_req && fc_staged[`TGC_FC_TX_EN];
      pause_suspend_tx  <= pause_frame_rx &&
                           fc_staged[`TGC_FC_RX_EN];
      pause_forward     <= pause_frame_rx &&
                           !fc_staged[`TGC_FC_RX_EN];
    end
  end

  // Defaults show in the same cycle as the reset pulse, not one later.
  assign tx_view = tx_rst_pend ? `TGC_TX_RESET_VAL : tx_act;
  assign adj_eff = tx_view[`TGC_TX_IFG_ADJ] && !tx_view[`TGC_TX_WAN];
endmodule

// ### tb/tgc_config_assertions.sv
// Port-level assertions for the configuration bank.
`timescale 1ns/1ns
module tgc_config_assertions (
  input wire logic        ref_clk, reset, host_rd, host_rd_valid,
  input wire logic [10:0] host_addr,
  input wire logic [31:0] host_rdata,
  input wire logic        pause_req, pause_frame_rx, pause_send,
  input wire logic        pause_suspend_tx, pause_forward, tx_run,
  input wire logic        tx_inband_fcs, tx_pad_and_fcs, tx_soft_reset,
  input wire logic        tx_ifg_adjust, tx_wan_mode, tx_deficit_idle
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rdv; 1 |=> host_rd_valid == $past(host_rd); endproperty
  a_rdv: assert property (p_rdv) else $error("read valid wrong");
  property p_fcr;
    $past(host_addr) == 11'h40c |-> (host_rdata & 32'h9fffffff) == 0;
  endproperty
  a_fcr: assert property (p_fcr) else $error("reserved bit read");
  property p_fcs; tx_inband_fcs != tx_pad_and_fcs; endproperty
  a_fcs: assert property (p_fcs) else $error("fcs modes clash");
  property p_ifg; tx_ifg_adjust |-> !tx_wan_mode && !tx_deficit_idle; endproperty
  a_ifg: assert property (p_ifg) else $error("gap adjust clash");
  // Reset pulse must carry transmit enable and last exactly one cycle.
  property p_srst; tx_soft_reset |-> tx_run ##1 !tx_soft_reset; endproperty
  a_srst: assert property (p_srst) else $error("soft reset wrong");
  property p_ps; !$past(pause_req) |-> !pause_send; endproperty
  a_ps: assert property (p_ps) else $error("pause without request");
  property p_rxp;
    $past(pause_frame_rx) && !$past(reset) |-> pause_suspend_tx != pause_forward;
  endproperty
  a_rxp: assert property (p_rxp) else $error("pause rx routing");
  property p_nop;
    !$past(pause_frame_rx) |-> !pause_suspend_tx && !pause_forward;
  endproperty
  a_nop: assert property (p_nop) else $error("spurious pause");
  c_rd: cover property (host_rd_valid);
  c_srst: cover property (tx_soft_reset);
  c_ps: cover property (pause_send);
endmodule

// ### tb/tgc_config_tb.sv
// Self-checking testbench for the configuration bank.
`timescale 1ns/1ns
module tgc_config_tb;
  logic        ref_clk = 0, reset = 1, host_wr = 0, host_rd = 0;
  logic [10:0] host_addr = 0;
  logic [31:0] host_wdata = 0, host_rdata;
  logic        rx_in_gap = 0, tx_in_gap = 0, pause_req = 0, pause_frame_rx = 0;
  logic        host_rd_valid, rx_keep_preamble, rx_len_type_check;
  logic        rx_ctl_len_check, tx_soft_reset, tx_jumbo, tx_inband_fcs;
  logic [15:0] pause_addr_upper;
  logic        tx_pad_and_fcs, tx_run, tx_vlan_allow, tx_wan_mode;
  logic        tx_ifg_adjust, tx_deficit_idle, tx_stretch_align;
  logic        tx_custom_preamble, pause_send, pause_suspend_tx, pause_forward;
  int          n_mismatch = 0, num_checks = 0;
  tgc_config i_tgc_config (.*);
  always #50 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    host_wr <= 1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge ref_clk);
    host_wr <= 0;
  endtask
  // Answer lands on the taking edge itself, so look just past it.
  task automatic rdc(input logic [10:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    host_rd <= 1;
    host_addr <= a;
    @(posedge ref_clk);
    host_rd <= 0;
    #1;
    chk(host_rd_valid, 1);
    chk(host_rdata, exp);
  endtask
  task automatic t_defaults;
    cyc(1);
    #1;
    chk({tx_run, tx_pad_and_fcs, rx_len_type_check, rx_ctl_len_check,
         tx_stretch_align, tx_jumbo, tx_vlan_allow, rx_keep_preamble},
        8'hf8);
    rdc(11'h404, 32'h0);
    rdc(11'h408, 32'h10000000);
    rdc(11'h40c, 32'h60000000);
    rdc(11'h410, 32'h0);
    $display("defaults done");
  endtask
  task automatic t_rx;
    wr(11'h404, 32'hffffffff);
    cyc(3);
    #1;
    chk(rx_keep_preamble, 0);
    rdc(11'h404, 32'h0700ffff);
    rx_in_gap <= 1;
    cyc(3);
    #1;
    chk({rx_keep_preamble, rx_len_type_check, rx_ctl_len_check,
         pause_addr_upper}, {3'b100, 16'hffff});
    $display("rx done");
  endtask
  task automatic t_tx;
    tx_in_gap <= 1;
    wr(11'h408, 32'h7fffffff);
    cyc(3);
    #1;
    chk({tx_jumbo, tx_inband_fcs, tx_pad_and_fcs, tx_run, tx_vlan_allow,
         tx_wan_mode, tx_ifg_adjust, tx_custom_preamble},
        8'hdd);
    wr(11'h408, 32'h03000000);
    rdc(11'h408, 32'h02000000);
    chk({tx_ifg_adjust, tx_deficit_idle, tx_run}, 3'b100);
    // No frames are sent, so no WAN jumbo frame exceeds the limit.
    wr(11'h408, 32'h80000000);
    cyc(1);
    #1;
    chk({tx_soft_reset, tx_run, tx_ifg_adjust}, 3'b110);
    rdc(11'h408, 32'h10000000);
    $display("tx done");
  endtask
  task automatic t_fc;
    pause_req <= 1;
    pause_frame_rx <= 1;
    cyc(2);
    #1;
    chk({pause_send, pause_suspend_tx, pause_forward}, 3'b110);
    wr(11'h40c, 32'h9fffffff);
    cyc(2);
    #1;
    chk({pause_send, pause_suspend_tx, pause_forward}, 3'b001);
    rdc(11'h40c, 32'h0);
    $display("flow control done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    reset <= 0;
    t_defaults;
    t_rx;
    t_tx;
    t_fc;
    wrap_up;
  end
  // About fifty cycles are needed; this allows forty times that.
  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
endmodule
bind tgc_config tgc_config_assertions i_tgc_config_assertions (.*);
